// [rtl/rhc_params.svh]
// rhc_params.svh: register indices, field positions, reset values
// and HDLC constants for the receive HDLC controller.
// Assumes inclusion by bare name from rtl/.
`ifndef RHC_PARAMS_SVH
`define RHC_PARAMS_SVH

// register indices; byte address is four times the index
`define RHC_IDX_CTRL 13'h0010
`define RHC_IDX_SUPP 13'h0011
`define RHC_IDX_FCTL 13'h0087
`define RHC_IDX_RTST 13'h00B4
`define RHC_IDX_DATA 13'h00B6
`define RHC_IDX_LAT 13'h00B7
`define RHC_IDX_MASK 13'h00B8
`define RHC_PORT_STRIDE 13'h0200

// control fields
`define RHC_CTRL_CHSEL 0
`define RHC_CTRL_MAP 5
`define RHC_CTRL_SRST 6
`define RHC_CTRL_CRCST 7

// latched status / mask bit positions
`define RHC_LAT_NE 0
`define RHC_LAT_HWM 1
`define RHC_LAT_END 2
`define RHC_LAT_ABT 3
`define RHC_LAT_OVR 4

// reset values
`define RHC_CTRL_RST 8'h00
`define RHC_SUPP_RST 8'h00
`define RHC_FCTL_RST 2'h0
`define RHC_MASK_RST 5'h00

// watermark thresholds in bytes
`define RHC_WM0 7'h04
`define RHC_WM1 7'h10
`define RHC_WM2 7'h20
`define RHC_WM3 7'h30

// hdlc bit-level constants
`define RHC_STUFF_ONES 3'h5
`define RHC_FLAG_ONES 3'h6
`define RHC_CRC_INIT 16'hFFFF
`define RHC_CRC_POLY 16'h8408
`define RHC_CRC_GOOD 16'hF0B8

`endif

// [rtl/rhc_pkg.sv]
// rhc_pkg: types shared by the receive HDLC controller files.
// Assumes no other package.
package rhc_pkg;
    typedef enum logic [1:0] {
        RHC_HUNT  = 2'h0,
        RHC_DATA  = 2'h1,
        RHC_DRAIN = 2'h3
    } rhc_state_e;

    typedef enum logic [2:0] {
        RHC_PS_BUSY  = 3'h0,
        RHC_PS_OK    = 3'h1,
        RHC_PS_CRC   = 3'h2,
        RHC_PS_ABORT = 3'h3,
        RHC_PS_OVR   = 3'h4
    } rhc_pkt_e;
endpackage : rhc_pkg

// [rtl/rhc_engine.sv]
// rhc_engine: bit-serial HDLC receive engine (flags, abort, destuffing,
// byte alignment, CRC16). Assumes bit strobes at least 4 clocks apart.
`timescale 1ns/10ps
`default_nettype none
`include "rhc_params.svh"
module rhc_engine
    import rhc_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // control
    input wire logic kill_i,
    input wire logic crc_store_i,
    // serial bits
    input wire logic bit_vld_i,
    input wire logic bit_i,
    // byte writes toward the fifo
    output logic wr_o,
    output logic [7:0] wr_data_o,
    output logic [2:0] wr_st_o
);
    rhc_state_e state_r;
    rhc_state_e after_r;
    rhc_pkt_e end_st_r;
    logic [2:0] ones_r;
    logic [7:0] sh_r;
    logic [2:0] bcnt_r;
    logic [15:0] crc_r;
    logic [15:0] crc_byte_r;
    logic [7:0] pend_r [3];
    logic [1:0] pcnt_r;
    logic [1:0] drain_r;
    logic [15:0] crc_nxt;
    logic [7:0] byte_nxt;
    logic is_abort;
    logic is_flag;
    logic is_stuff;
    logic good;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
        crc_step = (c >> 1) ^ ((c[0] ^ b) ? `RHC_CRC_POLY : 16'h0000);
    endfunction : crc_step

    assign crc_nxt = crc_step(crc_r, bit_i);
    assign byte_nxt = {bit_i, sh_r[7:1]};
    assign is_abort = bit_i && (ones_r == `RHC_FLAG_ONES);
    assign is_flag = !bit_i && (ones_r == `RHC_FLAG_ONES);
    assign is_stuff = !bit_i && (ones_r == `RHC_STUFF_ONES);
    // flag bits already shifted leave the assembler exactly at bit 7
    assign good = (bcnt_r == 3'h7) && (crc_byte_r == `RHC_CRC_GOOD) && (pcnt_r == 2'h3);

    // ones counter runs in every state so aborts and flags are seen anywhere
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ones_r <= 3'h0;
        end else if (kill_i) begin
            ones_r <= 3'h0;
        end else if (bit_vld_i) begin
            ones_r <= !bit_i ? 3'h0 : (ones_r == 3'h7) ? ones_r : ones_r + 3'h1;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= RHC_HUNT;
            after_r <= RHC_HUNT;
            end_st_r <= RHC_PS_BUSY;
            sh_r <= 8'h00;
            bcnt_r <= 3'h0;
            crc_r <= `RHC_CRC_INIT;
            crc_byte_r <= `RHC_CRC_INIT;
            pend_r <= '{default: 8'h00};
            pcnt_r <= 2'h0;
            drain_r <= 2'h0;
            wr_o <= 1'b0;
            wr_data_o <= 8'h00;
            wr_st_o <= RHC_PS_BUSY;
        end else if (kill_i) begin
            state_r <= RHC_HUNT;
            pcnt_r <= 2'h0;
            drain_r <= 2'h0;
            wr_o <= 1'b0;
        end else begin
            wr_o <= 1'b0;
            case (state_r)
                RHC_DRAIN: begin
                    wr_o <= 1'b1;
                    wr_data_o <= pend_r[0];
                    wr_st_o <= (drain_r == 2'h1) ? end_st_r : RHC_PS_BUSY;
                    pend_r[0] <= pend_r[1];
                    pend_r[1] <= pend_r[2];
                    drain_r <= drain_r - 2'h1;
                    if (drain_r == 2'h1) begin
                        state_r <= after_r;
                        pcnt_r <= 2'h0;
                    end
                end
                default: begin
                    if (bit_vld_i && is_abort) begin
                        // abort ends the frame with whatever bytes were held
                        state_r <= (state_r == RHC_DATA && pcnt_r != 2'h0) ? RHC_DRAIN : RHC_HUNT;
                        after_r <= RHC_HUNT;
                        end_st_r <= RHC_PS_ABORT;
                        drain_r <= pcnt_r;
                    end else if (bit_vld_i && is_flag) begin
                        // closing flag doubles as the next opening flag
                        bcnt_r <= 3'h0;
                        crc_r <= `RHC_CRC_INIT;
                        crc_byte_r <= `RHC_CRC_INIT;
                        after_r <= RHC_DATA;
                        if (state_r == RHC_DATA && pcnt_r != 2'h0) begin
                            state_r <= RHC_DRAIN;
                            end_st_r <= good ? RHC_PS_OK : RHC_PS_CRC;
                            // short frames have no valid crc: hand out all
                            drain_r <= (crc_store_i || pcnt_r != 2'h3) ? pcnt_r : 2'h1;
                        end else begin
                            state_r <= RHC_DATA;
                            pcnt_r <= 2'h0;
                        end
                    end else if (bit_vld_i && !is_stuff && state_r == RHC_DATA) begin
                        sh_r <= byte_nxt;
                        crc_r <= crc_nxt;
                        bcnt_r <= bcnt_r + 3'h1;
                        if (bcnt_r == 3'h7) begin
                            crc_byte_r <= crc_nxt;
                            // three bytes held back: two may be the crc
                            if (pcnt_r == 2'h3) begin
                                wr_o <= 1'b1;
                                wr_data_o <= pend_r[0];
                                wr_st_o <= RHC_PS_BUSY;
                                pend_r[0] <= pend_r[1];
                                pend_r[1] <= pend_r[2];
                                pend_r[2] <= byte_nxt;
                            end else begin
                                pend_r[pcnt_r] <= byte_nxt;
                                pcnt_r <= pcnt_r + 2'h1;
                            end
                        end
                    end
                end
            endcase
        end
    end

    AST_STUFF_DROP: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (bit_vld_i && is_stuff && state_r == RHC_DATA && !kill_i) |=> $stable(bcnt_r))
        else $error("stuffed zero entered the byte assembler");

    AST_ABORT_END: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (bit_vld_i && is_abort && state_r == RHC_DATA && pcnt_r != 2'h0 && !kill_i)
        |=> (state_r == RHC_DRAIN) && (end_st_r == RHC_PS_ABORT))
        else $error("abort did not end the frame with abort status");

    AST_CRC_KEEP: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (bit_vld_i && is_flag && state_r == RHC_DATA && pcnt_r == 2'h3 && !kill_i)
        |=> (drain_r == (crc_store_i ? 2'h3 : 2'h1)))
        else $error("wrong byte count handed out at frame end");

    AST_DRAIN_TAG: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (state_r == RHC_DRAIN && drain_r == 2'h1 && !kill_i) |=> (wr_o && wr_st_o != RHC_PS_BUSY))
        else $error("last byte of a frame carries no end status");
endmodule : rhc_engine
`default_nettype wire

// [rtl/rhc_top.sv]
// rhc_top: one port of the receive HDLC controller: stream selection,
// APB register file, 64-byte receive fifo, status and interrupt.
// Assumes the framer marks each received bit with channel, bit position
// and a data-link flag, and APB in the same clock domain.
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "rhc_params.svh"
module rhc_top
    import rhc_pkg::*;
#(
    parameter int PORT_N = 0,
    parameter int ADDR_W = 15,
    parameter int DEPTH = 64
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // received bit stream from the framer
    input wire logic rx_bit_vld_i,
    input wire logic rx_bit_i,
    input wire logic [4:0] rx_chan_i,
    input wire logic [2:0] rx_bitpos_i,
    input wire logic rx_dl_i,
    // flags
    output logic hwm_o,
    output logic int_o
);
    localparam int IW = ADDR_W - 2;
    localparam int PW = $clog2(DEPTH) + 1;
    localparam logic [IW-1:0] BASE = IW'(`RHC_PORT_STRIDE * PORT_N);

    logic [7:0] ctrl_r;
    logic [7:0] supp_r;
    logic [1:0] fctl_r;
    logic [4:0] mask_r;
    logic [4:0] lat_r;
    logic [4:0] lat_ev;
    logic [4:0] lat_clr;
    logic [2:0] last_ps_r;
    logic ne_q_r;
    logic hwm_q_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic pop_ok_r;
    logic eng_vld_r;
    logic eng_bit_r;
    logic [10:0] mem [DEPTH];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW-1:0] level;
    logic [PW-1:0] thr;
    logic [PW-1:0] wp_m1;
    logic full;
    logic empty;
    logic [IW-1:0] idx;
    logic acc_wr;
    logic acc_rd;
    logic hit_ctrl;
    logic hit_supp;
    logic hit_fctl;
    logic hit_rtst;
    logic hit_data;
    logic hit_lat;
    logic hit_mask;
    logic [7:0] rd_val;
    logic rd_err;
    logic take;
    logic srst_p;
    logic pop;
    logic eng_wr;
    logic [7:0] eng_data;
    logic [2:0] eng_st;
    logic wr_ok;
    logic ovr_ev;
    logic kill;

    // address decode
    assign idx = paddr_i[ADDR_W-1:2];
    assign hit_ctrl = idx == BASE + IW'(`RHC_IDX_CTRL);
    assign hit_supp = idx == BASE + IW'(`RHC_IDX_SUPP);
    assign hit_fctl = idx == BASE + IW'(`RHC_IDX_FCTL);
    assign hit_rtst = idx == BASE + IW'(`RHC_IDX_RTST);
    assign hit_data = idx == BASE + IW'(`RHC_IDX_DATA);
    assign hit_lat = idx == BASE + IW'(`RHC_IDX_LAT);
    assign hit_mask = idx == BASE + IW'(`RHC_IDX_MASK);
    assign acc_wr = psel_i && penable_i && pwrite_i;
    assign acc_rd = psel_i && penable_i && !pwrite_i;
    // zero wait states keep the fifo pop tied to a single edge
    assign pready_o = 1'b1;
    assign prdata_o = prdata_r;
    assign pslverr_o = pslverr_r;

    // fifo bookkeeping
    assign level = wp_r - rp_r;
    assign full = level == PW'(DEPTH);
    assign empty = level == '0;
    assign wp_m1 = wp_r - PW'(1);
    assign wr_ok = eng_wr && !full;
    assign ovr_ev = eng_wr && full;
    assign pop = acc_rd && hit_data && pop_ok_r;
    assign srst_p = acc_wr && hit_ctrl && pwdata_i[`RHC_CTRL_SRST] && !ctrl_r[`RHC_CTRL_SRST];
    assign kill = srst_p || ovr_ev;

    // source selection per received bit
    always_comb begin
        if (ctrl_r[`RHC_CTRL_MAP]) begin
            take = rx_bit_vld_i && rx_dl_i;
        end else begin
            take = rx_bit_vld_i && (rx_chan_i == ctrl_r[`RHC_CTRL_CHSEL +: 5])
                   && !supp_r[rx_bitpos_i];
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            eng_vld_r <= 1'b0;
            eng_bit_r <= 1'b0;
        end else begin
            eng_vld_r <= take;
            eng_bit_r <= rx_bit_i;
        end
    end

    rhc_engine u_engine (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .kill_i(kill),
        .crc_store_i(ctrl_r[`RHC_CTRL_CRCST]),
        .bit_vld_i(eng_vld_r),
        .bit_i(eng_bit_r),
        .wr_o(eng_wr),
        .wr_data_o(eng_data),
        .wr_st_o(eng_st)
    );

    // watermark threshold
    always_comb begin
        case (fctl_r)
            2'h0: thr = PW'(`RHC_WM0);
            2'h1: thr = PW'(`RHC_WM1);
            2'h2: thr = PW'(`RHC_WM2);
            default: thr = PW'(`RHC_WM3);
        endcase
    end
    assign hwm_o = level > thr;

    // fifo storage: status rides with each byte
    always_ff @(posedge mclk_i) begin
        if (wr_ok) begin
            mem[wp_r[PW-2:0]] <= {eng_st, eng_data};
        end else if (ovr_ev && !empty) begin
            mem[wp_m1[PW-2:0]][10:8] <= RHC_PS_OVR;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wp_r <= '0;
            rp_r <= '0;
            last_ps_r <= RHC_PS_BUSY;
        end else if (srst_p) begin
            wp_r <= '0;
            rp_r <= '0;
            last_ps_r <= RHC_PS_BUSY;
        end else begin
            if (wr_ok) begin
                wp_r <= wp_r + PW'(1);
            end
            if (pop) begin
                rp_r <= rp_r + PW'(1);
                last_ps_r <= mem[rp_r[PW-2:0]][10:8];
            end
        end
    end

    // configuration registers
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_r <= `RHC_CTRL_RST;
            supp_r <= `RHC_SUPP_RST;
            fctl_r <= `RHC_FCTL_RST;
            mask_r <= `RHC_MASK_RST;
        end else if (acc_wr) begin
            if (hit_ctrl) begin
                ctrl_r <= pwdata_i[7:0];
            end else if (hit_supp) begin
                supp_r <= pwdata_i[7:0];
            end else if (hit_fctl) begin
                fctl_r <= pwdata_i[1:0];
            end else if (hit_mask) begin
                mask_r <= pwdata_i[4:0];
            end
        end
    end

    // latched events; a new event wins over a same-cycle clear
    assign lat_ev[`RHC_LAT_NE] = !empty && !ne_q_r;
    assign lat_ev[`RHC_LAT_HWM] = hwm_o && !hwm_q_r;
    assign lat_ev[`RHC_LAT_END] = wr_ok && eng_st != RHC_PS_BUSY;
    assign lat_ev[`RHC_LAT_ABT] = wr_ok && eng_st == RHC_PS_ABORT;
    assign lat_ev[`RHC_LAT_OVR] = ovr_ev;
    assign lat_clr = (acc_wr && hit_lat) ? pwdata_i[4:0] : 5'h00;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lat_r <= 5'h00;
            ne_q_r <= 1'b0;
            hwm_q_r <= 1'b0;
        end else begin
            lat_r <= (lat_r & ~lat_clr) | lat_ev;
            ne_q_r <= !empty;
            hwm_q_r <= hwm_o;
        end
    end
    assign int_o = |(lat_r & mask_r);

    // read mux
    always_comb begin
        rd_val = 8'h00;
        rd_err = 1'b0;
        if (hit_ctrl) begin
            rd_val = ctrl_r;
        end else if (hit_supp) begin
            rd_val = supp_r;
        end else if (hit_fctl) begin
            rd_val = {6'h00, fctl_r};
        end else if (hit_rtst) begin
            rd_val = {1'b0, last_ps_r, 2'h0, hwm_o, !empty};
        end else if (hit_data) begin
            rd_val = empty ? 8'h00 : mem[rp_r[PW-2:0]][7:0];
        end else if (hit_lat) begin
            rd_val = {3'h0, lat_r};
        end else if (hit_mask) begin
            rd_val = {3'h0, mask_r};
        end else begin
            rd_err = 1'b1;
        end
    end

    // answer captured in the setup cycle, held through the access
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
            pop_ok_r <= 1'b0;
        end else if (psel_i && !penable_i) begin
            prdata_r <= {24'h000000, rd_val};
            pslverr_r <= rd_err;
            // a byte landing after setup must not be popped unseen
            pop_ok_r <= !empty;
        end
    end

    AST_MAP_DL: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (rx_bit_vld_i && ctrl_r[`RHC_CTRL_MAP] && !rx_dl_i) |=> !eng_vld_r)
        else $error("non data-link bit reached the engine");

    AST_CHAN_SEL: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (rx_bit_vld_i && !ctrl_r[`RHC_CTRL_MAP] && rx_chan_i != ctrl_r[4:0]) |=> !eng_vld_r)
        else $error("bit of an unselected channel reached the engine");

    AST_SUPPRESS: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (rx_bit_vld_i && !ctrl_r[`RHC_CTRL_MAP] && supp_r[rx_bitpos_i]) |=> !eng_vld_r)
        else $error("suppressed bit reached the engine");

    AST_FLUSH: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        srst_p |=> (empty && last_ps_r == RHC_PS_BUSY))
        else $error("soft reset did not flush the fifo");

    AST_DEPTH: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (full && !pop && !srst_p) |=> $stable(wp_r))
        else $error("fifo written beyond its depth");

    AST_HWM_RISE: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        $rose(hwm_o) |-> (level == thr + PW'(1)) || $changed(fctl_r))
        else $error("watermark flag rose at the wrong fill level");

    AST_WM48: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (fctl_r == 2'h3 && level == PW'(48)) |-> !hwm_o)
        else $error("watermark flag set at exactly the threshold");

    AST_HWM_INT: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ($rose(hwm_o) && mask_r[`RHC_LAT_HWM]) |=> int_o)
        else $error("enabled watermark did not raise the interrupt");

    AST_OVR: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ovr_ev |=> lat_r[`RHC_LAT_OVR])
        else $error("overrun not latched");

    AST_CTRL_WR: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (acc_wr && hit_ctrl) |=> (ctrl_r == $past(pwdata_i[7:0])))
        else $error("control write at port address not taken");
endmodule : rhc_top
`default_nettype wire

// [testbench/rhc_fm_model.sv]
// rhc_fm_model: framer side of one port, one bit strobe every 4 clocks.
// Assumes the bench loads line bits through push(); idle sends flags.
`timescale 1ns/10ps
`default_nettype none
module rhc_fm_model (
    // clock and selection
    input wire logic mclk_i,
    input wire logic [4:0] chan_i,
    input wire logic dl_i,
    input wire logic [7:0] skip_i,
    // framer stream
    output logic vld_o,
    output logic bit_o,
    output logic [4:0] chan_o,
    output logic [2:0] pos_o,
    output logic dl_o
);
    logic q[$];
    logic [7:0] flag = 8'h7E;
    logic [2:0] fi = 3'h0;
    int ph = 0;
    int slot = 0;
    task push(input logic b);
        q.push_back(b);
    endtask : push
    initial begin
        {vld_o, bit_o, chan_o, pos_o, dl_o} = '0;
    end
    // slots 0-7 target channel, 8-15 neighbour, 16 data link
    always @(posedge mclk_i) begin
        ph <= (ph + 1) % 4;
        vld_o <= (ph == 0);
        // unused slots toggle so a stale bit never looks valid
        bit_o <= ~bit_o;
        if (ph == 0) begin
            slot <= (slot == 16) ? 0 : slot + 1;
            chan_o <= (slot < 8) ? chan_i : chan_i ^ 5'h01;
            pos_o <= slot[2:0];
            dl_o <= (slot == 16);
            if (dl_i ? slot == 16 : slot < 8 && !skip_i[slot[2:0]]) begin
                // frames wait for a whole idle flag: a cut flag would form a byte
                if (q.size() != 0 && fi == 3'h0) begin
                    bit_o <= q.pop_front();
                end else begin
                    bit_o <= flag[fi];
                    fi <= fi + 3'h1;
                end
            end
        end
    end
endmodule : rhc_fm_model
`default_nettype wire

// [testbench/tb_top.sv]
// tb_top: register-level tests of one receive HDLC port (port 1).
// Assumes rhc_top and rhc_fm_model; APB in the design clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "rhc_params.svh"
module tb_top;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [14:0] pa = '0;
    logic [31:0] pwd = '0;
    logic [31:0] prd;
    logic prdy, perr, vld, bt, dl, hwm, irq;
    logic mdl = 1'b0;
    logic [4:0] ch;
    logic [4:0] mch = 5'h1F;
    logic [2:0] pos;
    logic [7:0] skip = 8'h00;
    logic [7:0] xq[$];
    logic [15:0] crc;
    logic [6:0] thr[4] = '{`RHC_WM0, `RHC_WM1, `RHC_WM2, `RHC_WM3};
    int fails = 0;
    int num_checks = 0;
    int ones = 0;
    always #2 mclk_i = ~mclk_i;
    rhc_top #(.PORT_N(1)) rhc_top_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
        .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
        .rx_bit_vld_i(vld), .rx_bit_i(bt), .rx_chan_i(ch), .rx_bitpos_i(pos),
        .rx_dl_i(dl), .hwm_o(hwm), .int_o(irq));
    rhc_fm_model fm (.mclk_i(mclk_i), .chan_i(mch), .dl_i(mdl), .skip_i(skip),
        .vld_o(vld), .bit_o(bt), .chan_o(ch), .pos_o(pos), .dl_o(dl));
    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    task chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    function automatic logic [14:0] ad(input logic [12:0] i);
        return {i + `RHC_PORT_STRIDE, 2'b00};
    endfunction : ad
    task apb(input logic w, input logic [14:0] a, input logic [7:0] d,
             output logic [7:0] q, output logic e);
        @(posedge mclk_i);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= {24'h0, d};
        @(posedge mclk_i);
        pen <= 1'b1;
        @(posedge mclk_i);
        while (prdy !== 1'b1) @(posedge mclk_i);
        q = prd[7:0];
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task wr(input logic [12:0] i, input logic [7:0] d);
        logic [7:0] q;
        logic e;
        apb(1'b1, ad(i), d, q, e);
    endtask : wr
    task rd(input logic [12:0] i, output logic [7:0] q);
        logic e;
        apb(1'b0, ad(i), 8'h00, q, e);
    endtask : rd
    task rc(input logic [12:0] i, input logic [7:0] x);
        logic [7:0] q;
        rd(i, q);
        chk(q, x);
    endtask : rc
    // flags are sampled mid-cycle, away from pointer updates
    task chb(input int s, input logic e);
        @(negedge mclk_i);
        chk({7'h0, s ? irq : hwm}, {7'h0, e});
    endtask : chb
    task pb(input logic b);
        fm.push(b);
        ones = b ? ones + 1 : 0;
    endtask : pb
    task sb(input logic [7:0] b, input logic st);
        for (int k = 0; k < 8; k++) begin
            pb(b[k]);
            if (st) crc = (crc >> 1) ^ ((crc[0] ^ b[k]) ? `RHC_CRC_POLY : 16'h0);
            if (st && ones == 5) pb(1'b0);
        end
    endtask : sb
    function automatic logic [7:0] pat(input int i);
        return (i % 3 == 0) ? 8'hFF : 8'(i * 75 + 29);
    endfunction : pat
    // m: 0 good, 1 corrupt crc, 2 abort
    task frame(input int n, input int m, input logic cs);
        logic [15:0] c;
        xq = {};
        crc = `RHC_CRC_INIT;
        sb(8'h7E, 1'b0);
        for (int i = 0; i < n; i++) begin
            sb(pat(i), 1'b1);
            xq.push_back(pat(i));
        end
        c = ~crc ^ ((m == 1) ? 16'h0001 : 16'h0000);
        if (m == 2) begin
            for (int k = 0; k < 7; k++) pb(1'b1);
        end else begin
            sb(c[7:0], 1'b1);
            sb(c[15:8], 1'b1);
        end
        if (cs) xq = {xq, c[7:0], c[15:8]};
        sb(8'h7E, 1'b0);
        while (fm.q.size() != 0) @(posedge mclk_i);
        // held bytes land a few clocks after the closing flag
        repeat (20) @(posedge mclk_i);
    endtask : frame
    task pop_n(input int n);
        logic [7:0] q;
        for (int i = 0; i < n; i++) rd(`RHC_IDX_DATA, q);
    endtask : pop_n
    // a source change splits one bit between model and design: restart engine
    task srst(input logic [7:0] c);
        wr(`RHC_IDX_CTRL, c | 8'h40);
        wr(`RHC_IDX_CTRL, c);
    endtask : srst
    task pop_chk(input logic [2:0] es, input logic cnt);
        int n;
        logic [7:0] q;
        logic [7:0] d;
        n = 0;
        rd(`RHC_IDX_RTST, q);
        while (q[0] === 1'b1 && n < 80) begin
            rd(`RHC_IDX_DATA, d);
            if (cnt && n < xq.size()) chk(d, xq[n]);
            n++;
            rd(`RHC_IDX_RTST, q);
            if (q[0] === 1'b1) chk({5'h0, q[6:4]}, 8'h00);
        end
        chk({5'h0, q[6:4]}, {5'h0, es});
        if (cnt) chk(8'(n), 8'(xq.size()));
    endtask : pop_chk
    initial begin
        #200000;
        fails++;
        $display("[FAIL] %0t watchdog expired", $time);
        give_verdict();
    end
    initial begin
        logic [7:0] q;
        logic e;
        int f;
        repeat (10) @(posedge mclk_i);
        rstn_i <= 1'b1;
        rc(`RHC_IDX_CTRL, `RHC_CTRL_RST);
        rc(`RHC_IDX_SUPP, `RHC_SUPP_RST);
        rc(`RHC_IDX_FCTL, 8'h00);
        rc(`RHC_IDX_MASK, 8'h00);
        apb(1'b0, 15'h0040, 8'h00, q, e);
        chk({7'h0, e}, 8'h01);
        wr(`RHC_IDX_CTRL, 8'h1F);
        rc(`RHC_IDX_CTRL, 8'h1F);
        frame(5, 0, 1'b0);
        pop_chk(3'h1, 1'b1);
        wr(`RHC_IDX_CTRL, 8'h9F);
        frame(5, 0, 1'b1);
        pop_chk(3'h1, 1'b1);
        wr(`RHC_IDX_CTRL, 8'h1F);
        frame(6, 1, 1'b0);
        pop_chk(3'h2, 1'b0);
        frame(8, 2, 1'b0);
        pop_chk(3'h3, 1'b0);
        wr(`RHC_IDX_SUPP, 8'h81);
        skip <= 8'h81;
        srst(8'h1F);
        frame(4, 0, 1'b0);
        pop_chk(3'h1, 1'b1);
        wr(`RHC_IDX_SUPP, 8'h00);
        skip <= 8'h00;
        wr(`RHC_IDX_CTRL, 8'h3F);
        mdl <= 1'b1;
        srst(8'h3F);
        frame(3, 0, 1'b0);
        pop_chk(3'h1, 1'b1);
        wr(`RHC_IDX_CTRL, 8'h1F);
        mdl <= 1'b0;
        srst(8'h1F);
        frame(49, 0, 1'b0);
        chb(1, 1'b0);
        wr(`RHC_IDX_MASK, 8'h02);
        chb(1, 1'b1);
        wr(`RHC_IDX_LAT, 8'h02);
        chb(1, 1'b0);
        wr(`RHC_IDX_FCTL, 8'h03);
        chb(0, 1'b1);
        f = 49;
        for (int k = 3; k >= 0; k--) begin
            pop_n(f - thr[k]);
            f = thr[k];
            wr(`RHC_IDX_FCTL, 8'(k));
            chb(0, 1'b0);
            if (k > 0) wr(`RHC_IDX_FCTL, 8'(k - 1));
            if (k > 0) chb(0, 1'b1);
        end
        rd(`RHC_IDX_RTST, q);
        chk(q & 8'h03, 8'h01);
        pop_chk(3'h1, 1'b0);
        frame(70, 0, 1'b0);
        xq = xq[0:63];
        pop_chk(3'h4, 1'b1);
        frame(5, 0, 1'b0);
        wr(`RHC_IDX_CTRL, 8'h5F);
        rd(`RHC_IDX_RTST, q);
        chk(q & 8'h01, 8'h00);
        frame(5, 0, 1'b0);
        wr(`RHC_IDX_CTRL, 8'h5F);
        rd(`RHC_IDX_RTST, q);
        chk(q & 8'h01, 8'h01);
        wr(`RHC_IDX_CTRL, 8'h1F);
        wr(`RHC_IDX_CTRL, 8'h5F);
        rd(`RHC_IDX_RTST, q);
        chk(q & 8'h01, 8'h00);
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
